/* File: hdl/psq_pkg.sv */
// constants, field layout and types of the psk / qam symbol sequencer
package psq_pkg;

	localparam int          CLK_HZ         = 40_000_000;
	localparam longint      BAUD_DEF_HZ    = 10_000;
	localparam int          INC_W          = 32;
	localparam int          LEN_W          = 9;

	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_START      = 8'h04;
	localparam logic [7:0]  OFF_SHIFT      = 8'h08;
	localparam logic [7:0]  OFF_PSK_BAUD   = 8'h0c;
	localparam logic [7:0]  OFF_QAM_BAUD   = 8'h10;
	localparam logic [7:0]  OFF_MARKER     = 8'h14;
	localparam logic [7:0]  OFF_LIST_CLR   = 8'h18;
	localparam logic [7:0]  OFF_LIST_DATA  = 8'h1c;
	localparam logic [7:0]  OFF_USER_CLR   = 8'h20;
	localparam logic [7:0]  OFF_USER_DATA  = 8'h24;
	localparam logic [7:0]  OFF_STATUS     = 8'h28;

	localparam int          CTRL_EN_BIT    = 0;
	localparam int          CTRL_CAR_BIT   = 1;
	localparam int          CTRL_QAM_BIT   = 2;
	localparam int          CTRL_PSK_LSB   = 4;
	localparam int          CTRL_QTYP_LSB  = 8;
	localparam int          ST_IDX_LSB     = 16;
	localparam int          ST_RUN_BIT     = 24;
	localparam int          ST_PEND_BIT    = 25;
	localparam int          ST_USER_LSB    = 26;

	localparam logic        RST_ENABLE     = 1'b0;
	localparam logic        RST_CARRIER    = 1'b1;
	localparam logic [8:0]  RST_START_DEG  = 9'h000;
	localparam logic [8:0]  RST_SHIFT_DEG  = 9'h0b4;
	localparam logic [8:0]  RST_MARKER     = 9'h001;
	localparam logic [8:0]  MARKER_MAX     = 9'h100;
	localparam logic [8:0]  DEG_MAX        = 9'h168;
	// accumulator step per clock giving the default baud
	localparam logic [INC_W-1:0] RST_BAUD_INC = INC_W'((BAUD_DEF_HZ <<< INC_W) / CLK_HZ);

	// degrees to a 16-bit fraction of a turn: deg * 46603 / 256
	localparam logic [24:0] DEG_TURN_MUL   = 25'h00b60b;
	localparam int          DEG_TURN_SH    = 8;
	localparam logic [15:0] QPSK_OFS       = 16'h2000;

	// amplitude steps per axis level, largest level stays below 127
	localparam logic [7:0]  QAM16_STEP     = 8'h28;
	localparam logic [7:0]  QAM64_STEP     = 8'h10;
	localparam logic [7:0]  QAM256_STEP    = 8'h08;

	typedef enum logic [2:0] {PSK_BASIC, PSK_BIN, PSK_QUAD, PSK_EIGHT, PSK_SIXTEEN, PSK_USER} psq_psk_t;
	typedef enum logic [1:0] {QAM_16, QAM_64, QAM_256, QAM_USER} psq_qam_t;

	typedef struct packed {
		logic              carrier_on;
		logic              is_qam;
		logic [15:0]       phase;
		logic signed [7:0] i_amp;
		logic signed [7:0] q_amp;
	} psq_sym_t;

endpackage : psq_pkg

/* File: hdl/psq_baud.sv */
// baud generator: phase accumulator producing one tick per baud period
`timescale 1ns/1ps
module psq_baud
	import psq_pkg::*;
#(
	parameter int ACC_W = INC_W
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             run,
	input  wire logic [ACC_W-1:0] inc,
	output logic                  tick
);

	logic [ACC_W-1:0] acc;
	logic [ACC_W:0]   next_acc;

	if (ACC_W < 8 || ACC_W > 48) begin : g_chk
		$error("psq_baud: ACC_W out of range");
	end

	assign next_acc = {1'b0, acc} + {1'b0, inc};

	// carry out of the accumulator marks a baud period
	always_ff @(posedge clk_sys) begin
		if (rst || !run) begin
			acc  <= '0;
			tick <= 1'b0;
		end else begin
			acc  <= next_acc[ACC_W-1:0];
			tick <= next_acc[ACC_W];
		end
	end

endmodule : psq_baud

/* File: hdl/psq_map.sv */
// symbol mapper: list entry to carrier phase or iq point
`timescale 1ns/1ps
module psq_map
	import psq_pkg::*;
(
	input  wire logic        [7:0]  sym,
	input  wire logic               is_qam,
	input  wire logic               carrier_on,
	input  wire psq_psk_t           psk_mode,
	input  wire psq_qam_t           qam_type,
	input  wire logic        [15:0] start_turn,
	input  wire logic        [15:0] shift_turn,
	input  wire logic        [15:0] user_word,
	output psq_sym_t                mapped
);

	logic [1:0] quad;
	logic [2:0] lvl_i;
	logic [2:0] lvl_q;
	logic [7:0] step;
	logic [7:0] mag_i;
	logic [7:0] mag_q;
	psq_sym_t   base;

	// phase path first; amplitudes are merged in below
	always_comb begin
		base            = '0;
		quad            = 2'h0;
		lvl_i           = 3'h0;
		lvl_q           = 3'h0;
		step            = 8'h00;
		base.is_qam     = is_qam;
		base.carrier_on = carrier_on;
		if (!is_qam) begin
			unique case (psk_mode)
				PSK_BASIC, PSK_BIN: base.phase = sym[0] ? shift_turn : start_turn;
				PSK_QUAD:    base.phase = {sym[1:0], 14'h0000} + QPSK_OFS;
				PSK_EIGHT:   base.phase = {sym[2:0], 13'h0000};
				PSK_SIXTEEN: base.phase = {sym[3:0], 12'h000};
				PSK_USER:    base.phase = user_word;
				default:     base.phase = start_turn;
			endcase
		end else begin
			unique case (qam_type)
				QAM_16: begin
					quad  = sym[3:2];
					lvl_i = {2'h0, sym[1]};
					lvl_q = {2'h0, sym[0]};
					step  = QAM16_STEP;
				end
				QAM_64: begin
					quad  = sym[5:4];
					lvl_i = {1'b0, sym[3:2]};
					lvl_q = {1'b0, sym[1:0]};
					step  = QAM64_STEP;
				end
				QAM_256: begin
					quad  = sym[7:6];
					lvl_i = sym[5:3];
					lvl_q = sym[2:0];
					step  = QAM256_STEP;
				end
				QAM_USER: begin
					step = 8'h00;
				end
			endcase
		end
	end

	// odd multiples of the step keep points centred in each quadrant
	assign mag_i = {4'h0, lvl_i, 1'b1} * step;
	assign mag_q = {4'h0, lvl_q, 1'b1} * step;

	psq_sym_t iq;
	always_comb begin
		iq = base;
		if (is_qam && qam_type == QAM_USER) begin
			iq.i_amp = user_word[15:8];
			iq.q_amp = user_word[7:0];
		end else if (is_qam) begin
			// 01 and 10 lie left, 10 and 11 lie low
			iq.i_amp = (quad[0] ^ quad[1]) ? -mag_i : mag_i;
			iq.q_amp = quad[1] ? -mag_q : mag_q;
		end
	end

	assign mapped = iq;

endmodule : psq_map

/* File: hdl/psq_seq_top.sv */
// symbol sequencer top: registers, symbol list, stepping, marker and output
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module psq_seq_top
	import psq_pkg::*;
#(
	parameter int LIST_DEPTH = 256,
	parameter int USER_DEPTH = 256
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        carrier_wrap,
	output psq_sym_t         sym_out,
	output logic             sym_strobe,
	output logic             sync_out
);

	localparam int LW = $clog2(LIST_DEPTH);
	localparam int UW = $clog2(USER_DEPTH);

	if (LIST_DEPTH < 2 || LIST_DEPTH > 256) begin : g_chk_list
		$error("psq_seq_top: LIST_DEPTH must be 2..256");
	end
	if (USER_DEPTH < 2 || USER_DEPTH > 256) begin : g_chk_user
		$error("psq_seq_top: USER_DEPTH must be 2..256");
	end

	logic             enable;
	logic             carrier_en;
	logic             qam_sel;
	psq_psk_t         psk_mode;
	psq_qam_t         qam_type;
	logic [8:0]       start_deg;
	logic [8:0]       shift_deg;
	logic [8:0]       marker;
	logic [8:0]       marker_act;
	logic [INC_W-1:0] psk_inc;
	logic [INC_W-1:0] qam_inc;
	logic [7:0]       list_mem [LIST_DEPTH];
	logic [15:0]      user_mem [USER_DEPTH];
	logic [LEN_W-1:0] list_len;
	logic [LEN_W-1:0] user_len;
	logic [LW-1:0]    idx;
	logic [LW-1:0]    pend_pos;
	logic             pend_valid;
	psq_sym_t         pend;
	psq_sym_t         mapped;
	logic [31:0]      rd_val;

	logic wr_ctrl;
	logic wr_list_clr;
	logic wr_list_data;
	logic wr_user_clr;
	logic wr_user_data;
	assign wr_ctrl      = reg_wr && reg_addr == OFF_CTRL;
	assign wr_list_clr  = reg_wr && reg_addr == OFF_LIST_CLR;
	assign wr_list_data = reg_wr && reg_addr == OFF_LIST_DATA;
	assign wr_user_clr  = reg_wr && reg_addr == OFF_USER_CLR;
	assign wr_user_data = reg_wr && reg_addr == OFF_USER_DATA;

	function automatic logic [8:0] clamp9(input logic [31:0] v, input logic [8:0] lo, input logic [8:0] hi);
		logic [8:0] r;
		r = hi;
		if (v < {23'h0, lo})
			r = lo;
		else if (v <= {23'h0, hi})
			r = v[8:0];
		return r;
	endfunction : clamp9

	// mode and enable controls
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			enable     <= RST_ENABLE;
			carrier_en <= RST_CARRIER;
			qam_sel    <= 1'b0;
			psk_mode   <= PSK_BASIC;
			qam_type   <= QAM_16;
		end else if (wr_ctrl) begin
			enable     <= reg_wdata[CTRL_EN_BIT];
			carrier_en <= reg_wdata[CTRL_CAR_BIT];
			qam_sel    <= reg_wdata[CTRL_QAM_BIT];
			psk_mode   <= psq_psk_t'(reg_wdata[CTRL_PSK_LSB +: 3]);
			qam_type   <= psq_qam_t'(reg_wdata[CTRL_QTYP_LSB +: 2]);
		end
	end

	// phases, clamped into 0..360 degrees
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			start_deg <= RST_START_DEG;
			shift_deg <= RST_SHIFT_DEG;
		end else begin
			if (reg_wr && reg_addr == OFF_START)
				start_deg <= clamp9(reg_wdata, 9'h000, DEG_MAX);
			if (reg_wr && reg_addr == OFF_SHIFT)
				shift_deg <= clamp9(reg_wdata, 9'h000, DEG_MAX);
		end
	end

	// baud steps: tick rate is inc * clock / 2^32
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			psk_inc <= RST_BAUD_INC;
			qam_inc <= RST_BAUD_INC;
		end else begin
			if (reg_wr && reg_addr == OFF_PSK_BAUD)
				psk_inc <= reg_wdata;
			if (reg_wr && reg_addr == OFF_QAM_BAUD)
				qam_inc <= reg_wdata;
		end
	end

	// marker is captured when a list load starts, so a later write
	// only lands with the next load
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			marker     <= RST_MARKER;
			marker_act <= RST_MARKER;
		end else begin
			if (reg_wr && reg_addr == OFF_MARKER)
				marker <= clamp9(reg_wdata, RST_MARKER, MARKER_MAX);
			if (wr_list_clr)
				marker_act <= marker;
		end
	end

	// symbol list: clear, then append entries in order
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			list_len <= '0;
			for (int k = 0; k < LIST_DEPTH; k++)
				list_mem[k] <= 8'h00;
		end else if (wr_list_clr) begin
			list_len <= '0;
		end else if (wr_list_data && list_len < LEN_W'(LIST_DEPTH)) begin
			list_mem[list_len[LW-1:0]] <= reg_wdata[7:0];
			list_len <= list_len + 9'h001;
		end
	end

	// user table: index rises from 0 with each appended entry
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			user_len <= '0;
			for (int k = 0; k < USER_DEPTH; k++)
				user_mem[k] <= 16'h0000;
		end else if (wr_user_clr) begin
			user_len <= '0;
		end else if (wr_user_data && user_len < LEN_W'(USER_DEPTH)) begin
			user_mem[user_len[UW-1:0]] <= reg_wdata[15:0];
			user_len <= user_len + 9'h001;
		end
	end

	// sequencing
	logic        running;
	logic        basic;
	logic        baud_tick;
	logic        step_go;
	logic        last;
	logic        apply;
	logic [7:0]  cur_sym;
	logic [15:0] start_turn;
	logic [15:0] shift_turn;

	assign running    = enable && list_len != '0;
	assign basic      = !qam_sel && psk_mode == PSK_BASIC;
	assign cur_sym    = list_mem[idx];
	assign last       = LEN_W'(idx) == list_len - 9'h001;
	assign start_turn = 16'((25'(start_deg) * DEG_TURN_MUL) >> DEG_TURN_SH);
	assign shift_turn = 16'((25'(shift_deg) * DEG_TURN_MUL) >> DEG_TURN_SH);
	// basic mode has no baud of its own: it steps once per carrier cycle
	assign step_go    = running && (basic ? carrier_wrap : baud_tick);
	// without a carrier there is no cycle to finish
	assign apply      = pend_valid && (carrier_wrap || !pend.carrier_on);

	psq_baud #(
		.ACC_W(INC_W)
	) u_baud (
		.clk_sys(clk_sys),
		.rst    (rst),
		.run    (running && !basic),
		.inc    (qam_sel ? qam_inc : psk_inc),
		.tick   (baud_tick)
	);

	psq_map u_map (
		.sym       (cur_sym),
		.is_qam    (qam_sel),
		.carrier_on(carrier_en || basic),
		.psk_mode  (psk_mode),
		.qam_type  (qam_type),
		.start_turn(start_turn),
		.shift_turn(shift_turn),
		.user_word (user_mem[cur_sym[UW-1:0]]),
		.mapped    (mapped)
	);

	always_ff @(posedge clk_sys) begin
		if (rst || !running) begin
			idx <= '0;
		end else if (step_go) begin
			idx <= last ? '0 : idx + 1'b1;
		end
	end

	// pending symbol waits for the carrier cycle boundary when its carrier is on; a new step
	// in the same cycle as the apply wins over the clear
	always_ff @(posedge clk_sys) begin
		if (rst || !running) begin
			pend_valid <= 1'b0;
			pend       <= '0;
			pend_pos   <= '0;
		end else if (step_go) begin
			pend_valid <= 1'b1;
			pend       <= mapped;
			pend_pos   <= idx;
		end else if (apply) begin
			pend_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sym_out    <= '0;
			sym_strobe <= 1'b0;
			sync_out   <= 1'b0;
		end else begin
			sym_strobe <= apply;
			sync_out   <= apply && LEN_W'(pend_pos) + 9'h001 == marker_act;
			if (apply)
				sym_out <= pend;
		end
	end

	// register read port, data valid one cycle after the strobe
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (reg_addr)
			OFF_CTRL: begin
				rd_val[CTRL_EN_BIT]            = enable;
				rd_val[CTRL_CAR_BIT]           = carrier_en;
				rd_val[CTRL_QAM_BIT]           = qam_sel;
				rd_val[CTRL_PSK_LSB +: 3]      = psk_mode;
				rd_val[CTRL_QTYP_LSB +: 2]     = qam_type;
			end
			OFF_START:    rd_val[8:0] = start_deg;
			OFF_SHIFT:    rd_val[8:0] = shift_deg;
			OFF_PSK_BAUD: rd_val      = psk_inc;
			OFF_QAM_BAUD: rd_val      = qam_inc;
			OFF_MARKER:   rd_val[8:0] = marker;
			OFF_STATUS: begin
				rd_val[LEN_W-1:0]          = list_len;
				rd_val[ST_IDX_LSB +: 8]    = 8'(idx);
				rd_val[ST_RUN_BIT]         = running;
				rd_val[ST_PEND_BIT]        = pend_valid;
				rd_val[ST_USER_LSB +: 6]   = user_len[LEN_W-1 -: 6];
			end
			default:      rd_val      = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? rd_val : 32'h0000_0000;
	end

	// checks
	chk_list_order: assert property (@(posedge clk_sys) disable iff (rst)
		step_go && !last && !wr_list_clr && !wr_ctrl |=> idx == $past(idx) + 1'b1)
		else $error("list index did not advance by one");

	chk_list_wrap: assert property (@(posedge clk_sys) disable iff (rst)
		step_go && last && !wr_list_clr |=> idx == '0)
		else $error("list index did not wrap after last entry");

	chk_cycle_finish: assert property (@(posedge clk_sys) disable iff (rst)
		sym_strobe && sym_out.carrier_on |-> $past(carrier_wrap))
		else $error("symbol applied inside a carrier cycle");

	chk_marker_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		apply && LEN_W'(pend_pos) + 9'h001 == marker_act |=> sync_out && sym_strobe)
		else $error("marker pulse missing at index");

	chk_basic_hold: assert property (@(posedge clk_sys) disable iff (rst)
		running && basic && !carrier_wrap && !wr_ctrl && !wr_list_clr |=> idx == $past(idx))
		else $error("basic mode stepped without carrier cycle");

	chk_carrier_gate: assert property (@(posedge clk_sys) disable iff (rst)
		step_go |=> pend.carrier_on == $past(carrier_en || basic))
		else $error("carrier enable not applied");

	chk_binary_phase: assert property (@(posedge clk_sys) disable iff (rst)
		step_go && !qam_sel && psk_mode == PSK_BIN
		|=> pend.phase == ($past(cur_sym[0]) ? $past(shift_turn) : $past(start_turn)))
		else $error("binary symbol chose wrong phase");

	chk_sixteen_vec: assert property (@(posedge clk_sys) disable iff (rst)
		step_go && !qam_sel && psk_mode == PSK_SIXTEEN
		|=> pend.phase == {$past(cur_sym[3:0]), 12'h000})
		else $error("sixteen-phase vector mismatch");

	chk_qam_quadrant: assert property (@(posedge clk_sys) disable iff (rst)
		step_go && qam_sel && qam_type == QAM_16
		|=> pend.i_amp[7] == $past(cur_sym[3] ^ cur_sym[2]) && pend.q_amp[7] == $past(cur_sym[3]))
		else $error("qam quadrant signs wrong");

endmodule : psq_seq_top

/* File: tb/psq_synth_model.sv */
// synthesis path stand-in: one carrier_wrap pulse per carrier cycle
`timescale 1ns/1ps
module psq_synth_model
	import psq_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [7:0] wrap_period,
	output logic            carrier_wrap
);
	logic [7:0] cyc_cnt;

	// the carrier runs free, so wraps keep coming between symbols too
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cyc_cnt      <= 8'h00;
			carrier_wrap <= 1'b0;
		end else begin
			carrier_wrap <= (cyc_cnt == wrap_period - 8'h01);
			cyc_cnt      <= (cyc_cnt >= wrap_period - 8'h01) ? 8'h00 : cyc_cnt + 8'h01;
		end
	end
endmodule : psq_synth_model

/* File: tb/psq_seq_top_test.sv */
// self-checking bench of the symbol sequencer top
`timescale 1ns/1ps
module psq_seq_top_test
	import psq_pkg::*;
;
	logic        clk_sys;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        carrier_wrap;
	psq_sym_t    sym_out;
	logic        sym_strobe;
	logic        sync_out;
	logic [7:0]  wrap_period;
	logic        wrap_d1;
	int          mismatches;
	int          cmp_count;
	integer      seed;
	logic [8:0]  start_deg;
	logic [8:0]  shift_deg;
	logic [15:0] user_tab[8];
	logic [7:0]  list_tab[8];
	int          pbits[6] = '{1, 1, 2, 3, 4, 3};

	psq_seq_top i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .carrier_wrap(carrier_wrap),
		.sym_out(sym_out), .sym_strobe(sym_strobe), .sync_out(sync_out));
	psq_synth_model i_synth (.clk_sys(clk_sys), .rst(rst), .wrap_period(wrap_period),
		.carrier_wrap(carrier_wrap));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic fail(input string what);
		mismatches++;
		$display("MISMATCH t=%0t %s", $time, what);
	endtask : fail

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fail($sformatf("%s got %h exp %h", what, got, exp));
		end
	endtask : chk

	// a new phase may only land on a completed carrier cycle
	always @(posedge clk_sys) begin
		// strobe trails the wrap that applied it by one clock
		wrap_d1 <= carrier_wrap;
		if (!rst && sym_strobe === 1'b1 && sym_out.carrier_on === 1'b1 && wrap_d1 !== 1'b1) begin
			fail("symbol applied mid carrier cycle");
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata & msk, exp, $sformatf("read %h", a));
	endtask : rdchk

	task automatic wait_strobe(output int gap);
		gap = 0;
		for (int t = 0; t < 300; t++) begin
			@(posedge clk_sys);
			#1;
			gap++;
			if (sym_strobe === 1'b1) begin
				return;
			end
		end
		fail("no symbol strobe");
	endtask : wait_strobe

	function automatic logic [15:0] deg_turn(input logic [8:0] d);
		logic [24:0] p;
		p = 25'(d) * 25'd46603;
		return p[23:8];
	endfunction : deg_turn

	function automatic logic [15:0] exp_phase(input int md, input logic [7:0] s);
		case (md)
			0, 1: return s[0] ? deg_turn(shift_deg) : deg_turn(start_deg);
			2: return {s[1:0], 14'h2000};
			3: return {s[2:0], 13'h0000};
			4: return {s[3:0], 12'h000};
			default: return user_tab[s[2:0]];
		endcase
	endfunction : exp_phase

	function automatic logic [15:0] exp_iq(input int qt, input logic [7:0] s);
		int h;
		logic [7:0] st;
		logic [7:0] ia;
		logic [7:0] qa;
		logic [1:0] qd;
		h  = qt + 1;
		st = (qt == 0) ? 8'h28 : (qt == 1) ? 8'h10 : 8'h08;
		qd = 2'(s >> (2 * h));
		ia = 8'((2 * ((s >> h) & ((1 << h) - 1)) + 1) * st);
		qa = 8'((2 * (s & ((1 << h) - 1)) + 1) * st);
		if (qd == 2'h1 || qd == 2'h2) begin
			ia = -ia;
		end
		if (qd[1]) begin
			qa = -qa;
		end
		return {ia, qa};
	endfunction : exp_iq

	task automatic run(input logic q, input int md, input logic car);
		int n;
		int mk;
		int gap;
		int idx;
		int bits;
		logic [7:0] s;
		logic user;
		n    = 2 + ($unsigned($random(seed)) % 7);
		mk   = 1 + ($unsigned($random(seed)) % n);
		bits = q ? ((md == 3) ? 3 : 4 + 2 * md) : pbits[md];
		user = q ? (md == 3) : (md == 5);
		wr(OFF_CTRL, 32'(car) << 1);
		wrap_period <= 8'(2 + $unsigned($random(seed)) % 8);
		wr(OFF_PSK_BAUD, (q || md == 0) ? 32'h0 : 32'h10000000);
		wr(OFF_QAM_BAUD, q ? 32'h10000000 : 32'h0);
		start_deg = 9'($unsigned($random(seed)) % 360);
		shift_deg = 9'($unsigned($random(seed)) % 360);
		wr(OFF_START, 32'(start_deg));
		wr(OFF_SHIFT, 32'(shift_deg));
		if (user) begin
			wr(OFF_USER_CLR, 32'h0);
			for (int i = 0; i < 8; i++) begin
				user_tab[i] = 16'($random(seed));
				wr(OFF_USER_DATA, 32'(user_tab[i]));
			end
		end
		wr(OFF_MARKER, 32'(mk));
		wr(OFF_LIST_CLR, 32'h0);
		for (int i = 0; i < n; i++) begin
			list_tab[i] = 8'($random(seed)) & 8'((1 << bits) - 1);
			wr(OFF_LIST_DATA, 32'(list_tab[i]));
		end
		rdchk(OFF_STATUS, 32'(n), 32'h1ff);
		wr(OFF_CTRL, 32'h1 | (32'(car) << 1) | (32'(q) << 2) | (32'(md) << (q ? 8 : 4)));
		for (int k = 0; k < n + 3; k++) begin
			wait_strobe(gap);
			idx = k % n;
			s   = list_tab[idx];
			chk({sym_out.carrier_on, sym_out.is_qam}, {car | (!q && md == 0), q}, "carrier or kind");
			if (q) begin
				chk({sym_out.i_amp, sym_out.q_amp}, user ? user_tab[s[2:0]] : exp_iq(md, s), "iq");
			end else begin
				chk(sym_out.phase, exp_phase(md, s), "phase");
			end
			chk(sync_out, 32'(idx + 1 == mk), "marker");
			if (!car && k > 0 && (q || md != 0)) begin
				chk(gap, 32'd16, "baud spacing");
			end
		end
		wr(OFF_CTRL, 32'(car) << 1);
	endtask : run

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (60000) @(posedge clk_sys);
		fail("watchdog expired");
		wrap_up();
	end

	initial begin
		seed        = 32'h589e;
		mismatches  = 0;
		cmp_count   = 0;
		rst         = 1'b1;
		reg_addr    = 8'h00;
		reg_wdata   = 32'h0;
		reg_wr      = 1'b0;
		reg_rd      = 1'b0;
		wrap_period = 8'h04;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		rdchk(OFF_CTRL, 32'h2, 32'hffffffff);
		rdchk(OFF_START, 32'h0, 32'hffffffff);
		rdchk(OFF_SHIFT, 32'hb4, 32'hffffffff);
		rdchk(OFF_QAM_BAUD, 32'h0010624d, 32'hffffffff);
		rdchk(OFF_MARKER, 32'h1, 32'hffffffff);
		rdchk(8'hfc, 32'h0, 32'hffffffff);
		wr(OFF_MARKER, 32'h0);
		rdchk(OFF_MARKER, 32'h1, 32'hffffffff);
		wr(OFF_MARKER, 32'h12c);
		rdchk(OFF_MARKER, 32'h100, 32'hffffffff);
		for (int md = 0; md < 6; md++) begin
			run(1'b0, md, !(md == 0 || md == 4));
		end
		for (int qt = 0; qt < 4; qt++) begin
			run(1'b1, qt, qt[0]);
		end
		wrap_up();
	end
endmodule : psq_seq_top_test
